// *** include/irq_pkg.sv ***
package irq_pkg;
  localparam logic [7:0] FLAGS1_ADDR = 8'h0c;
  localparam logic [7:0] ENABLES2_ADDR = 8'h8d;
  localparam logic [7:0] FLAGS1_RESET = 8'h00;
  localparam logic [7:0] ENABLES2_RESET = 8'h00;
  localparam int CONV_BIT = 6;
  localparam int SERIAL_BIT = 3;
  localparam int CCP_BIT = 2;
  localparam int TIMER_TWO_BIT = 1;
  localparam int TIMER_ONE_BIT = 0;
  localparam int EE_EN_BIT = 4;
  localparam int BCL_EN_BIT = 3;
  localparam logic [7:0] FLAGS1_EVENT_MASK = 8'h4f;
  localparam logic [7:0] FLAGS1_RSVD_MASK = 8'hb0;
  localparam logic [7:0] ENABLES2_IMPL_MASK = 8'h59;
  localparam logic [7:0] ENABLES2_RSVD_MASK = 8'h41;

  typedef enum logic [1:0] {SSP_OFF, SSP_SPI, SSP_I2C_SLAVE, SSP_I2C_MASTER} ssp_mode_t;
  typedef enum logic [1:0] {CCP_OFF, CCP_CAPTURE, CCP_COMPARE, CCP_PWM} ccp_mode_t;

  // APB register map of the controller end
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CMD_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] EVENT_OFS = 12'h00c;
  localparam int CTRL_GIE_BIT = 0;
  localparam int CTRL_PERIPHERAL_IRQ_GATE_BIT = 1;
  localparam int CTRL_EE_FLAG_BIT = 2;
  localparam int CTRL_BCL_FLAG_BIT = 3;
  localparam int CTRL_SSP_IDLE_BIT = 4;
  localparam int CTRL_EN1_LSB = 8;
  localparam int CTRL_SSP_MODE_LSB = 16;
  localparam int CTRL_CCP_MODE_LSB = 20;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STATUS_BUSY_BIT = 8;
  localparam int STATUS_IRQ_BIT = 9;
  localparam int EV_CONV_BIT = 0;
  localparam int EV_SSP_XFER_BIT = 1;
  localparam int EV_SSP_SEQ_BIT = 2;
  localparam int EV_SSP_BUS_BIT = 3;
  localparam int EV_CAPTURE_BIT = 4;
  localparam int EV_MATCH_BIT = 5;
  localparam int EV_TIMER_TWO_BIT = 6;
  localparam int EV_TIMER_ONE_BIT = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage : irq_pkg

// *** include/irq_link_if.sv ***
`timescale 1ns/1ns
interface irq_link_if;
  import irq_pkg::*;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic conv_done;
  ssp_mode_t ssp_mode;
  logic ssp_xfer_done;
  logic ssp_seq_done;
  logic ssp_bus_cond;
  logic ssp_idle;
  ccp_mode_t ccp_mode;
  logic ccp_capture;
  logic ccp_match;
  logic timer_two_match;
  logic timer_one_overflow;
  logic [7:0] enables_1;
  logic ee_write_flag;
  logic bus_collision_flag;
  logic global_irq_enable;
  logic peripheral_irq_gate;
  logic periph_irq_req;

  modport dev (
    input reg_addr, reg_wr, reg_rd, reg_wdata, conv_done, ssp_mode, ssp_xfer_done, ssp_seq_done,
    input ssp_bus_cond, ssp_idle, ccp_mode, ccp_capture, ccp_match, timer_two_match, timer_one_overflow,
    input enables_1, ee_write_flag, bus_collision_flag, global_irq_enable, peripheral_irq_gate,
    output reg_rdata, periph_irq_req
  );
  modport host (
    output reg_addr, reg_wr, reg_rd, reg_wdata, conv_done, ssp_mode, ssp_xfer_done, ssp_seq_done,
    output ssp_bus_cond, ssp_idle, ccp_mode, ccp_capture, ccp_match, timer_two_match, timer_one_overflow,
    output enables_1, ee_write_flag, bus_collision_flag, global_irq_enable, peripheral_irq_gate,
    input reg_rdata, periph_irq_req
  );
endinterface : irq_link_if

// *** rtl/irq_flags_dev.sv ***
`timescale 1ns/1ns
module irq_flags_dev (
  input wire logic MCLK, // System clock
  input wire logic RST, // Asynchronous reset, active high
  irq_link_if.dev LINK, // Register port and event lines
  output logic [7:0] FLAGS_VIEW, // Flag register contents
  output logic [7:0] ENABLES_VIEW // Second enable register contents
);
  import irq_pkg::*;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] rdata;
    logic irq;
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;
  logic [7:0] set_vec;

  function automatic logic [7:0] read_sel(input logic [7:0] addr, input dev_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (addr == FLAGS1_ADDR)
    begin
      v = s.flags;
    end
    else if (addr == ENABLES2_ADDR)
    begin
      v = s.enables & ENABLES2_IMPL_MASK;
    end
    return v;
  endfunction : read_sel

  always_comb
  begin
    state_next = state_reg;
    set_vec = 8'h00;
    // Events are taken with no look at any enable
    set_vec[CONV_BIT] = LINK.conv_done;
    set_vec[SERIAL_BIT] = LINK.ssp_xfer_done && (LINK.ssp_mode != SSP_OFF);
    if (LINK.ssp_mode == SSP_I2C_MASTER)
    begin
      if (LINK.ssp_seq_done)
      begin
        set_vec[SERIAL_BIT] = 1'b1;
      end
      if (LINK.ssp_bus_cond && LINK.ssp_idle)
      begin
        set_vec[SERIAL_BIT] = 1'b1;
      end
    end
    case (LINK.ccp_mode)
      CCP_CAPTURE: set_vec[CCP_BIT] = LINK.ccp_capture;
      CCP_COMPARE: set_vec[CCP_BIT] = LINK.ccp_match;
      CCP_PWM: set_vec[CCP_BIT] = 1'b0;
      default: set_vec[CCP_BIT] = 1'b0;
    endcase
    set_vec[TIMER_TWO_BIT] = LINK.timer_two_match;
    set_vec[TIMER_ONE_BIT] = LINK.timer_one_overflow;
    if (LINK.reg_wr && (LINK.reg_addr == FLAGS1_ADDR))
    begin
      state_next.flags = LINK.reg_wdata;
    end
    if (LINK.reg_wr && (LINK.reg_addr == ENABLES2_ADDR))
    begin
      state_next.enables = LINK.reg_wdata & ENABLES2_IMPL_MASK;
    end
    // An event in the cycle of a clearing write survives it
    state_next.flags = state_next.flags | set_vec;
    if (LINK.reg_rd)
    begin
      state_next.rdata = read_sel(LINK.reg_addr, state_reg);
    end
    state_next.irq = LINK.global_irq_enable && LINK.peripheral_irq_gate &&
      ((|(state_reg.flags & LINK.enables_1 & FLAGS1_EVENT_MASK)) ||
       (LINK.ee_write_flag && state_reg.enables[EE_EN_BIT]) ||
       (LINK.bus_collision_flag && state_reg.enables[BCL_EN_BIT]));
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= '{flags: FLAGS1_RESET, enables: ENABLES2_RESET, rdata: 8'h00, irq: 1'b0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign LINK.reg_rdata = state_reg.rdata;
  assign LINK.periph_irq_req = state_reg.irq;
  assign FLAGS_VIEW = state_reg.flags;
  assign ENABLES_VIEW = state_reg.enables;
endmodule : irq_flags_dev

// *** rtl/irq_flags_host.sv ***
`timescale 1ns/1ns
module irq_flags_host (
  input wire logic MCLK, // System clock
  input wire logic RST, // Asynchronous reset, active high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  irq_link_if.host LINK // Link to the flag device
);
  import irq_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_ISSUE, PH_CAPTURE} phase_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] events;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic link_wr;
    logic link_rd;
    phase_t phase;
    logic [7:0] rdata;
    logic [31:0] prdata;
  } host_state_t;

  host_state_t state_reg;
  host_state_t state_next;
  logic wr_access;

  function automatic logic mapped(input logic [11:0] a);
    return (a == CTRL_OFS) || (a == CMD_OFS) || (a == STATUS_OFS) || (a == EVENT_OFS);
  endfunction : mapped

  // Software is trusted to keep reserved positions clear; the relay forces them anyway
  function automatic logic [7:0] scrub(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == FLAGS1_ADDR)
    begin
      v = d & ~FLAGS1_RSVD_MASK;
    end
    else if (a == ENABLES2_ADDR)
    begin
      v = d & ~ENABLES2_RSVD_MASK;
    end
    return v;
  endfunction : scrub

  assign wr_access = PSEL && PENABLE && PWRITE;

  always_comb
  begin
    state_next = state_reg;
    state_next.events = 8'h00;
    state_next.link_wr = 1'b0;
    state_next.link_rd = 1'b0;
    // Read data is prepared in the setup cycle so the answer needs no wait state
    if (PSEL && !PENABLE)
    begin
      state_next.prdata = 32'h0000_0000;
      case (PADDR)
        CTRL_OFS: state_next.prdata = state_reg.ctrl;
        CMD_OFS: state_next.prdata = {15'h0000, state_reg.write, state_reg.addr, state_reg.wdata};
        STATUS_OFS: state_next.prdata = {22'h000000, LINK.periph_irq_req,
          (state_reg.phase != PH_IDLE), state_reg.rdata};
        default: state_next.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_access && (PADDR == CTRL_OFS))
    begin
      state_next.ctrl = PWDATA;
    end
    if (wr_access && (PADDR == EVENT_OFS))
    begin
      state_next.events = PWDATA[7:0];
    end
    case (state_reg.phase)
      PH_IDLE:
      begin
        // Clearing a stale flag before enabling it is left to the order of commands
        if (wr_access && (PADDR == CMD_OFS))
        begin
          state_next.addr = PWDATA[CMD_ADDR_LSB +: 8];
          state_next.write = PWDATA[CMD_WRITE_BIT];
          state_next.wdata = scrub(PWDATA[CMD_ADDR_LSB +: 8], PWDATA[7:0]);
          state_next.link_wr = PWDATA[CMD_WRITE_BIT];
          state_next.link_rd = !PWDATA[CMD_WRITE_BIT];
          state_next.phase = PH_ISSUE;
        end
      end
      PH_ISSUE: state_next.phase = PH_CAPTURE;
      PH_CAPTURE:
      begin
        if (!state_reg.write)
        begin
          state_next.rdata = LINK.reg_rdata;
        end
        state_next.phase = PH_IDLE;
      end
      default: state_next.phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= '{ctrl: CTRL_RESET, events: 8'h00, addr: 8'h00, wdata: 8'h00, write: 1'b0,
        link_wr: 1'b0, link_rd: 1'b0, phase: PH_IDLE, rdata: 8'h00, prdata: 32'h0000_0000};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign PRDATA = state_reg.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);
  assign LINK.reg_addr = state_reg.addr;
  assign LINK.reg_wdata = state_reg.wdata;
  assign LINK.reg_wr = state_reg.link_wr;
  assign LINK.reg_rd = state_reg.link_rd;
  assign LINK.global_irq_enable = state_reg.ctrl[CTRL_GIE_BIT];
  assign LINK.peripheral_irq_gate = state_reg.ctrl[CTRL_PERIPHERAL_IRQ_GATE_BIT];
  assign LINK.ee_write_flag = state_reg.ctrl[CTRL_EE_FLAG_BIT];
  assign LINK.bus_collision_flag = state_reg.ctrl[CTRL_BCL_FLAG_BIT];
  assign LINK.ssp_idle = state_reg.ctrl[CTRL_SSP_IDLE_BIT];
  assign LINK.enables_1 = state_reg.ctrl[CTRL_EN1_LSB +: 8];
  assign LINK.ssp_mode = ssp_mode_t'(state_reg.ctrl[CTRL_SSP_MODE_LSB +: 2]);
  assign LINK.ccp_mode = ccp_mode_t'(state_reg.ctrl[CTRL_CCP_MODE_LSB +: 2]);
  assign LINK.conv_done = state_reg.events[EV_CONV_BIT];
  assign LINK.ssp_xfer_done = state_reg.events[EV_SSP_XFER_BIT];
  assign LINK.ssp_seq_done = state_reg.events[EV_SSP_SEQ_BIT];
  assign LINK.ssp_bus_cond = state_reg.events[EV_SSP_BUS_BIT];
  assign LINK.ccp_capture = state_reg.events[EV_CAPTURE_BIT];
  assign LINK.ccp_match = state_reg.events[EV_MATCH_BIT];
  assign LINK.timer_two_match = state_reg.events[EV_TIMER_TWO_BIT];
  assign LINK.timer_one_overflow = state_reg.events[EV_TIMER_ONE_BIT];
endmodule : irq_flags_host

// *** tb/irq_flags_asserts.sv ***
`timescale 1ns/1ns
module irq_flags_asserts (
  input wire logic MCLK, // clock
  input wire logic RST, // reset
  input wire logic conv_done, // event
  input wire irq_pkg::ssp_mode_t ssp_mode, // mode
  input wire logic ssp_xfer_done, // event
  input wire logic ssp_seq_done, // event
  input wire logic ssp_bus_cond, // event
  input wire logic ssp_idle, // level
  input wire irq_pkg::ccp_mode_t ccp_mode, // mode
  input wire logic ccp_capture, // event
  input wire logic ccp_match, // event
  input wire logic timer_two_match, // event
  input wire logic timer_one_overflow, // event
  input wire logic [7:0] enables_1, // level
  input wire logic global_irq_enable, // level
  input wire logic peripheral_irq_gate, // level
  input wire logic periph_irq_req // request
);
  import irq_pkg::*;
  logic [7:0] en;
  // Enables that can reach the request once both gates are open
  assign en = (global_irq_enable && peripheral_irq_gate) ? enables_1 : 8'h00;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  property p_conv;
    conv_done && en[6] ##1 en[6] |=> periph_irq_req;
  endproperty
  a_conv: assert property (p_conv) else $error("conversion gave no request");
  property p_xfer;
    ssp_xfer_done && ssp_mode != SSP_OFF && en[3] ##1 en[3] |=> periph_irq_req;
  endproperty
  a_xfer: assert property (p_xfer) else $error("serial transfer gave no request");
  property p_seq;
    ssp_seq_done && ssp_mode == SSP_I2C_MASTER && en[3] ##1 en[3] |=> periph_irq_req;
  endproperty
  a_seq: assert property (p_seq) else $error("sequence end gave no request");
  property p_bus;
    ssp_bus_cond && ssp_idle && ssp_mode == SSP_I2C_MASTER && en[3] ##1 en[3] |=> periph_irq_req;
  endproperty
  a_bus: assert property (p_bus) else $error("bus condition gave no request");
  property p_cap;
    ccp_capture && ccp_mode == CCP_CAPTURE && en[2] ##1 en[2] |=> periph_irq_req;
  endproperty
  a_cap: assert property (p_cap) else $error("capture gave no request");
  property p_cmp;
    ccp_match && ccp_mode == CCP_COMPARE && en[2] ##1 en[2] |=> periph_irq_req;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare match gave no request");
  property p_timer_two;
    timer_two_match && en[1] ##1 en[1] |=> periph_irq_req;
  endproperty
  a_timer_two: assert property (p_timer_two) else $error("period match gave no request");
  property p_timer_one;
    timer_one_overflow && en[0] ##1 en[0] |=> periph_irq_req;
  endproperty
  a_timer_one: assert property (p_timer_one) else $error("overflow gave no request");
  property p_gate;
    !(global_irq_enable && peripheral_irq_gate) |=> !periph_irq_req;
  endproperty
  a_gate: assert property (p_gate) else $error("request while gated");
  property p_rst;
    // One edge late: the request is unknown until the first clocked reset
    disable iff (1'b0) RST |=> !periph_irq_req;
  endproperty
  a_rst: assert property (p_rst) else $error("request during reset");
endmodule : irq_flags_asserts

// *** tb/peripheral_irq_flags_enables_tb.sv ***
`timescale 1ns/1ns
module peripheral_irq_flags_enables_tb;
  import irq_pkg::*;
  typedef struct packed {logic [31:0] ctrl; logic [7:0] ev; logic [7:0] flags;} ev_case_t;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [7:0] flags_view;
  logic [7:0] enables_view;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int num_checks = 0;
  ev_case_t cases [17];
  irq_link_if link();
  irq_flags_dev i_irq_flags_dev (.MCLK(MCLK), .RST(RST), .LINK(link), .FLAGS_VIEW(flags_view),
    .ENABLES_VIEW(enables_view));
  irq_flags_host i_irq_flags_host (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK(link));
  irq_flags_asserts i_irq_flags_asserts (.MCLK(MCLK), .RST(RST), .conv_done(link.conv_done),
    .ssp_mode(link.ssp_mode), .ssp_xfer_done(link.ssp_xfer_done), .ssp_seq_done(link.ssp_seq_done),
    .ssp_bus_cond(link.ssp_bus_cond), .ssp_idle(link.ssp_idle), .ccp_mode(link.ccp_mode),
    .ccp_capture(link.ccp_capture), .ccp_match(link.ccp_match), .timer_two_match(link.timer_two_match),
    .timer_one_overflow(link.timer_one_overflow), .enables_1(link.enables_1),
    .global_irq_enable(link.global_irq_enable), .peripheral_irq_gate(link.peripheral_irq_gate),
    .periph_irq_req(link.periph_irq_req));
  initial
  begin
    forever #50 MCLK = ~MCLK;
  end
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic give_up;
    failures++;
    final_report();
  endtask : give_up
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge MCLK);
      if (PREADY === 1'b1)
        break;
    end
    if (n == 20)
      give_up();
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  // Device access goes through the command register; poll until the host is idle
  task automatic cmd(input logic [31:0] c);
    int n;
    apb(1'b1, CMD_OFS, c);
    for (n = 0; n < 20; n++)
    begin
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      if (rd[STATUS_BUSY_BIT] === 1'b0)
        break;
    end
    if (n == 20)
      give_up();
  endtask : cmd
  // The request is registered behind the link levels, so let two edges pass first
  task automatic irq_is(input logic x);
    repeat (2) @(posedge MCLK);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("irq", 32'(rd[STATUS_IRQ_BIT]), 32'(x));
  endtask : irq_is
  task automatic run_case(input ev_case_t c);
    apb(1'b1, CTRL_OFS, c.ctrl);
    apb(1'b1, EVENT_OFS, 32'(c.ev));
    repeat (3) @(posedge MCLK);
    chk("flags", 32'(flags_view), 32'(c.flags));
    irq_is(c.ctrl[0] & c.ctrl[1] & |(c.flags & c.ctrl[15:8]));
    chk("held", 32'(flags_view), 32'(c.flags));
    cmd(32'h0001_0c00);
    chk("cleared", 32'(flags_view), 32'h0000_0000);
  endtask : run_case
  initial
  begin
    cases[0] = '{32'h0000_4f00, 8'h01, 8'h40};
    cases[1] = '{32'h0001_4f13, 8'h02, 8'h08};
    cases[2] = '{32'h0002_4f13, 8'h02, 8'h08};
    cases[3] = '{32'h0000_4f13, 8'h02, 8'h00};
    cases[4] = '{32'h0003_4f13, 8'h04, 8'h08};
    cases[5] = '{32'h0001_4f13, 8'h04, 8'h00};
    cases[6] = '{32'h0003_4f13, 8'h08, 8'h08};
    cases[7] = '{32'h0003_4f03, 8'h08, 8'h00};
    cases[8] = '{32'h0010_4f13, 8'h10, 8'h04};
    cases[9] = '{32'h0010_4f13, 8'h20, 8'h00};
    cases[10] = '{32'h0020_4f13, 8'h20, 8'h04};
    cases[11] = '{32'h0030_4f13, 8'h30, 8'h00};
    cases[12] = '{32'h0000_4f13, 8'h40, 8'h02};
    cases[13] = '{32'h0000_4f13, 8'h80, 8'h01};
    cases[14] = '{32'h0000_4f11, 8'h01, 8'h40};
    cases[15] = '{32'h0000_4f13, 8'h01, 8'h40};
    cases[16] = '{32'h0000_0013, 8'hc0, 8'h03};
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk("ctrl", rd, CTRL_RESET);
    cmd(32'h0000_0c00);
    chk("flags_rst", 32'(rd[7:0]), 32'(FLAGS1_RESET));
    cmd(32'h0000_8d00);
    chk("enables_rst", 32'(rd[7:0]), 32'(ENABLES2_RESET));
    cmd(32'h0001_0cff);
    chk("flags_rsvd", 32'(flags_view), 32'h0000_004f);
    cmd(32'h0001_0c00);
    foreach (cases[i])
      run_case(cases[i]);
    cmd(32'h0001_8dff);
    chk("enables_view", 32'(enables_view), 32'h0000_0018);
    cmd(32'h0000_8d00);
    chk("enables_rd", 32'(rd[7:0]), 32'h0000_0018);
    cmd(32'h0001_8d10);
    apb(1'b1, CTRL_OFS, 32'h0000_0007);
    irq_is(1'b1);
    apb(1'b1, CTRL_OFS, 32'h0000_000b);
    irq_is(1'b0);
    cmd(32'h0001_8d08);
    irq_is(1'b1);
    apb(1'b1, CTRL_OFS, 32'h0000_0007);
    irq_is(1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped_err", 32'(err), 32'h0000_0001);
    chk("unmapped_rd", rd, 32'h0000_0000);
    final_report();
  end
endmodule : peripheral_irq_flags_enables_tb
